// [src/adapter_cfg_pkg.sv]
// Register map, field positions and reset values of the adapter config bank
package adapter_cfg_pkg;
    localparam logic [7:0] ADDR_CONNECTIVITY = 8'h68;
    localparam logic [7:0] ADDR_TX_RX_CONFIG = 8'h70;
    localparam logic [7:0] ADDR_GP_PORT = 8'h78;
    localparam logic [7:0] ADDR_STATUS = 8'h7c;
    localparam logic [31:0] RESET_CONNECTIVITY = 32'hffff0000;
    localparam logic [31:0] RESET_TX_RX_CONFIG = 32'h00000000;
    localparam logic [31:0] RESET_GP_PORT = 32'h00000000;
    localparam int POS_ADAPTER_RESET_N = 0;
    localparam int POS_IFACE_SELECT = 3;
    localparam int POS_COAX_SELECT = 3;
    localparam int POS_ADV_FOUR_PAIR_100 = 18;
    localparam int POS_ADV_TWO_PAIR_100_FULL = 17;
    localparam int POS_ADV_TWO_PAIR_100_HALF = 16;
    localparam int POS_PORT_AUTOSENSE_EN = 15;
    localparam int POS_AUTONEG_EN = 7;
    localparam int POS_ADV_TWISTED_10_HALF = 6;
    localparam int LCW_FOUR_PAIR_100 = 9;
    localparam int LCW_TWO_PAIR_100_FULL = 8;
    localparam int LCW_TWO_PAIR_100_HALF = 7;
    localparam int LCW_TWISTED_10_HALF = 5;
    localparam logic [4:0] LCW_SELECTOR = 5'h01;
    localparam int LCW_WIDTH = 16;
endpackage

// [src/cfg_reg.sv]
// One software register with reset value and byte-lane writes
module cfg_reg
    import adapter_cfg_pkg::*;
#(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic write_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] data_i,
    output logic [31:0] value_o
);
    typedef struct packed {
        logic [31:0] value;
    } reg_state_t;
    reg_state_t state;
    reg_state_t next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < 4; i++) begin
            if (write_i && sel_i[i]) begin
                next_state.value[i*8 +: 8] = data_i[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.value <= RESET_VALUE;
        end else begin
            state <= next_state;
        end
    end

    assign value_o = state.value;
endmodule

// [src/lcw_assembler.sv]
// Builds the transmitted link code word from the advertisement bits
module lcw_assembler
    import adapter_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [31:0] config_i,
    output logic [LCW_WIDTH-1:0] word_o
);
    typedef struct packed {
        logic [LCW_WIDTH-1:0] word;
    } lcw_state_t;
    lcw_state_t state;
    lcw_state_t next_state;

    always_comb begin
        next_state = state;
        if (load_i) begin
            next_state.word = '0;
            next_state.word[4:0] = LCW_SELECTOR;
            next_state.word[LCW_FOUR_PAIR_100] = config_i[POS_ADV_FOUR_PAIR_100];
            next_state.word[LCW_TWO_PAIR_100_FULL] = config_i[POS_ADV_TWO_PAIR_100_FULL];
            next_state.word[LCW_TWO_PAIR_100_HALF] = config_i[POS_ADV_TWO_PAIR_100_HALF];
            next_state.word[LCW_TWISTED_10_HALF] = config_i[POS_ADV_TWISTED_10_HALF];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.word <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign word_o = state.word;
endmodule

// [src/serial_port_media_config.sv]
// Wishbone register bank steering the serial interface adapter media setup
module serial_port_media_config
    import adapter_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic lcw_load_i,
    output logic [LCW_WIDTH-1:0] lcw_word_o,
    output logic lcw_valid_o,
    output logic adapter_reset_n_o,
    output logic aui_select_o,
    output logic thin_coax_select_o,
    output logic monitor_twisted_o,
    output logic monitor_aui_o,
    output logic autoneg_active_o
);
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic lcw_valid;
    } bus_state_t;
    bus_state_t state;
    bus_state_t next_state;

    logic [31:0] connectivity;
    logic [31:0] tx_rx_config;
    logic [31:0] gp_port;
    logic req;
    logic write_conn;
    logic write_txrx;
    logic write_gp;
    logic hit;
    logic autoneg_run;
    logic [LCW_WIDTH-1:0] word;
    logic [31:0] status_word;

    // New request only while no answer is standing
    assign req = wb_cyc_i && wb_stb_i && !state.ack && !state.err;
    assign hit = (wb_adr_i == ADDR_CONNECTIVITY) || (wb_adr_i == ADDR_TX_RX_CONFIG)
        || (wb_adr_i == ADDR_GP_PORT) || (wb_adr_i == ADDR_STATUS);
    assign write_conn = req && wb_we_i && (wb_adr_i == ADDR_CONNECTIVITY);
    assign write_txrx = req && wb_we_i && (wb_adr_i == ADDR_TX_RX_CONFIG);
    assign write_gp = req && wb_we_i && (wb_adr_i == ADDR_GP_PORT);

    cfg_reg #(
        .RESET_VALUE(RESET_CONNECTIVITY)
    ) u_connectivity (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .write_i(write_conn),
        .sel_i(wb_sel_i),
        .data_i(wb_dat_i),
        .value_o(connectivity)
    );

    cfg_reg #(
        .RESET_VALUE(RESET_TX_RX_CONFIG)
    ) u_tx_rx_config (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .write_i(write_txrx),
        .sel_i(wb_sel_i),
        .data_i(wb_dat_i),
        .value_o(tx_rx_config)
    );

    cfg_reg #(
        .RESET_VALUE(RESET_GP_PORT)
    ) u_gp_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .write_i(write_gp),
        .sel_i(wb_sel_i),
        .data_i(wb_dat_i),
        .value_o(gp_port)
    );

    assign adapter_reset_n_o = connectivity[POS_ADAPTER_RESET_N];
    assign aui_select_o = connectivity[POS_IFACE_SELECT];
    assign thin_coax_select_o = gp_port[POS_COAX_SELECT];
    assign monitor_twisted_o = adapter_reset_n_o
        && (tx_rx_config[POS_PORT_AUTOSENSE_EN] || !aui_select_o);
    assign monitor_aui_o = adapter_reset_n_o
        && (tx_rx_config[POS_PORT_AUTOSENSE_EN] || aui_select_o);
    assign autoneg_run = adapter_reset_n_o && tx_rx_config[POS_AUTONEG_EN] && !aui_select_o;
    assign autoneg_active_o = autoneg_run;

    // Adapter reset also clears the word builder
    // load gated by autoneg_run: autoneg enable set, adapter out of reset and AUI not selected
    lcw_assembler u_lcw (
        .clk_i(clk_i),
        .rst_i(rst_i || !adapter_reset_n_o),
        .load_i(lcw_load_i && autoneg_run),
        .config_i(tx_rx_config),
        .word_o(word)
    );
    assign lcw_word_o = word;

    assign status_word = {26'h0000000, autoneg_run, monitor_aui_o, monitor_twisted_o,
        thin_coax_select_o, aui_select_o, adapter_reset_n_o};

    always_comb begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.err = 1'b0;
        // Valid drops with reset or autoneg leaving
        if (!autoneg_run) begin
            next_state.lcw_valid = 1'b0;
        end else if (lcw_load_i) begin
            next_state.lcw_valid = 1'b1;
        end
        if (req) begin
            next_state.ack = hit;
            next_state.err = !hit;
            next_state.rdata = 32'h00000000;
            if (!wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_CONNECTIVITY: next_state.rdata = connectivity;
                    ADDR_TX_RX_CONFIG: next_state.rdata = tx_rx_config;
                    ADDR_GP_PORT: next_state.rdata = gp_port;
                    ADDR_STATUS: next_state.rdata = status_word;
                    default: next_state.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wb_ack_o = state.ack;
    assign wb_err_o = state.err;
    assign wb_dat_o = state.rdata;
    assign lcw_valid_o = state.lcw_valid;
endmodule

// [verification/spmc_chk.sv]
// Assertion checker for the adapter config bank
module spmc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lcw_load_i,
    input wire logic [15:0] lcw_word_o,
    input wire logic lcw_valid_o,
    input wire logic adapter_reset_n_o,
    input wire logic aui_select_o,
    input wire logic monitor_twisted_o,
    input wire logic monitor_aui_o,
    input wire logic autoneg_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Adapter running on both edges, no load
    sequence s_idle; (!lcw_load_i && adapter_reset_n_o) ##1 adapter_reset_n_o; endsequence
    property p_off; !adapter_reset_n_o |-> !(monitor_twisted_o | monitor_aui_o); endproperty
    a_off: assert property (p_off) else $error("monitor in reset");
    property p_clr; !adapter_reset_n_o |=> lcw_word_o == 16'h0; endproperty
    a_clr: assert property (p_clr) else $error("word kept in reset");
    property p_sel; adapter_reset_n_o |-> (aui_select_o ? monitor_aui_o : monitor_twisted_o);
    endproperty
    a_sel: assert property (p_sel) else $error("selected port idle");
    property p_one; monitor_twisted_o != monitor_aui_o |-> monitor_aui_o == aui_select_o;
    endproperty
    a_one: assert property (p_one) else $error("wrong single port");
    property p_neg; autoneg_active_o |-> adapter_reset_n_o && !aui_select_o; endproperty
    a_neg: assert property (p_neg) else $error("negotiation off twisted");
    property p_load; lcw_load_i && autoneg_active_o |=> lcw_valid_o && lcw_word_o[4:0] == 5'h01;
    endproperty
    a_load: assert property (p_load) else $error("word not built");
    property p_ign; lcw_load_i && !autoneg_active_o |=> !lcw_valid_o; endproperty
    a_ign: assert property (p_ign) else $error("word valid without autoneg");
    property p_hold; s_idle |-> $stable(lcw_word_o); endproperty
    a_hold: assert property (p_hold) else $error("word changed without load");
endmodule
bind serial_port_media_config spmc_chk u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lcw_load_i(lcw_load_i),
    .lcw_word_o(lcw_word_o),
    .lcw_valid_o(lcw_valid_o),
    .adapter_reset_n_o(adapter_reset_n_o),
    .aui_select_o(aui_select_o),
    .monitor_twisted_o(monitor_twisted_o),
    .monitor_aui_o(monitor_aui_o),
    .autoneg_active_o(autoneg_active_o)
);

// [verification/tb_top.sv]
// Self-checking bench for the adapter config bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic lcw_load_i = 1'b0, wb_ack_o, wb_err_o, lcw_valid_o, er;
    logic adapter_reset_n_o, aui_select_o, thin_coax_select_o;
    logic monitor_twisted_o, monitor_aui_o, autoneg_active_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sl = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [15:0] lcw_word_o, ew = 16'h0;
    int bad_count = 0, n_tests = 0, p[4] = '{18, 17, 16, 6}, b[4] = '{9, 8, 7, 5};
    wire logic [4:0] st = {adapter_reset_n_o, aui_select_o, monitor_twisted_o, monitor_aui_o,
        autoneg_active_o};
    serial_port_media_config DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .lcw_load_i(lcw_load_i),
        .lcw_word_o(lcw_word_o),
        .lcw_valid_o(lcw_valid_o),
        .adapter_reset_n_o(adapter_reset_n_o),
        .aui_select_o(aui_select_o),
        .thin_coax_select_o(thin_coax_select_o),
        .monitor_twisted_o(monitor_twisted_o),
        .monitor_aui_o(monitor_aui_o),
        .autoneg_active_o(autoneg_active_o)
    );
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Holds the request until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sl;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            bad_count++;
            results();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic load;
        lcw_load_i <= 1'b1;
        @(posedge clk_i);
        lcw_load_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_reset;
        bus(1'b0, 8'h68, 32'h0);
        chk("conn", rd, 32'hffff0000);
        chk("state", st, 5'h00);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", er, 1'b1);
    endtask
    task automatic t_select;
        bus(1'b1, 8'h70, 32'h80);
        bus(1'b1, 8'h68, 32'h1);
        chk("twisted", st, 5'h15);
        bus(1'b1, 8'h68, 32'h9);
        chk("aui", st, 5'h1a);
        bus(1'b1, 8'h78, 32'h8);
        chk("coax", {thin_coax_select_o, st}, 6'h3a);
        bus(1'b1, 8'h70, 32'h8080);
        chk("sense", st, 5'h1e);
        bus(1'b0, 8'h7c, 32'h0);
        chk("status", rd, 32'h0000001f);
        bus(1'b1, 8'h68, 32'h8);
        chk("held", st, 5'h08);
    endtask
    task automatic t_adv;
        bus(1'b1, 8'h68, 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h70, 32'h80 | (32'h1 << p[i]));
            chk("old", lcw_word_o, ew);
            load();
            ew = 16'h1 | (16'h1 << b[i]);
            chk("word", {lcw_valid_o, lcw_word_o}, {1'b1, ew});
        end
        bus(1'b1, 8'h70, 32'h70040);
        load();
        chk("noneg", {lcw_valid_o, lcw_word_o}, {1'b0, ew});
        bus(1'b1, 8'h70, 32'h700c0);
        bus(1'b1, 8'h68, 32'h9);
        load();
        chk("aui", lcw_valid_o, 1'b0);
        bus(1'b1, 8'h68, 32'h0);
        chk("clr", lcw_word_o, 16'h0);
        sl = 4'h4;
        bus(1'b1, 8'h70, 32'haa01bbcc);
        sl = 4'hf;
        bus(1'b0, 8'h70, 32'h0);
        chk("lane", rd, 32'h000100c0);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_select();
        t_adv();
        results();
    end
endmodule
